// file: rtl/backlight_level_fade_control.sv
// Summary of operation
// - Bit 7 picks the second light input for level control, else the main input.
// - Bit 6 enables the second light input and turns sink six off.
// - Level codes 0 to 4 are levels one to five; higher codes give zero current.
// - Level field shows the level in use; writes force it; auto mode overwrites it.
// - Transfer law codes 00 and 01 are square law; cubic codes 10 and 11 bend the step timing.
// - Bit 0 turns the fade override on when set.
// - A set group bit makes that sink independent; clear follows backlight enable.
// - A set PWM bit lets the external PWM scale that sink; clear ignores it.
// - Off timeout in whole seconds turns the backlight off; zero disables it.
// - With dim timeout enabled, off timeout counts only after dim expires.
// - Dim timeout in whole seconds moves to dim current; zero disables it.
// - Dim timeout counting starts only once maximum current is reached.
// - Fade-out code gives 0.1 s, then 0.3 s steps to 3.0 s, then 0.5 s steps.
// - Fade-in uses the same encoding, ramping up to maximum on turn-on.
// - A fade-out ramps from present current to dim or off value.
// - Fade times are for full scale; shorter swings take proportionally less time.
// - Rate code zero still ramps, finishing in about 100 ms.
// - Auto mode makes the level follow the comparators over software writes.
// - Dim expiry sets the dim flag; software may force it only while enabled.
// - The backlight-off flag is raised when an automated fade profile completes.
`timescale 1ns/100ps
`default_nettype none
module backlight_level_fade_control #(
  parameter int TICK_CYCLES_P = backlight_pkg::TICK_CYCLES, // Cycles per second tick.
  parameter int FADE_UNIT_CYCLES_P = backlight_pkg::FADE_UNIT_CYCLES // Cycles per code, 0.1 s.
) (
  input wire logic clk, // System clock, 100 MHz.
  input wire logic sys_rst, // Synchronous reset, active high.
  input wire logic reg_wr_en, // Register write strobe.
  input wire logic reg_rd_en, // Register read strobe.
  input wire logic [7:0] reg_addr, // Register offset.
  input wire logic [7:0] reg_wdata, // Register write data.
  output logic [7:0] reg_rdata, // Read data, valid the cycle after reg_rd_en.
  input wire logic backlight_enable, // Common backlight enable.
  input wire logic auto_level_enable, // Automatic comparator level control.
  input wire logic dim_force, // Software request to enter dim mode.
  input wire logic [2:0] main_light_level, // Level chosen by the main light input.
  input wire logic [2:0] second_light_level, // Level chosen by the second light input.
  input wire logic [6:0] level_max_current, // Maximum current code of the level in use.
  input wire logic [6:0] level_dim_current, // Dim current code of the level in use.
  input wire logic pwm_in, // External PWM input.
  output logic [2:0] brightness_level, // Level field in use.
  output logic [1:0] transfer_law, // Transfer law code.
  output logic second_sensor_on, // Second light input enabled.
  output logic [6:0] backlight_current, // Present backlight current code.
  output logic [6:0] sink_group_on, // Sink driven by the common backlight.
  output logic [6:0] sink_independent, // Sink runs as an independent sink.
  output logic [6:0] sink_pwm_gate, // Per-sink PWM scale gate, 1 passes current.
  output logic dim_mode, // Dim mode flag.
  output logic backlight_off_event // One-cycle pulse when a fade profile ends.
);
  import backlight_pkg::*;

  typedef struct packed {
    logic [7:0] cfg;
    logic [6:0] grp;
    logic [6:0] pwm;
    logic [6:0] off_timeout_secs;
    logic [6:0] dim_timeout_secs;
    logic [7:0] rates;
    seq_state_t st;
    logic [6:0] cur;
    logic [26:0] tick;
    logic [6:0] tcnt;
    logic dim_mode;
    logic off_latched;
    logic off_evt;
    logic [7:0] rdata;
  } ctl_t;

  ctl_t q_ff;
  ctl_t nxt_q;
  logic [2:0] lvl;
  logic lvl_ok;
  logic [6:0] max_tgt;
  logic [6:0] dim_tgt;
  logic [6:0] fade_tgt;
  logic fading;
  logic step;
  logic [3:0] rate_code;
  logic tick_hit;
  logic [6:0] dim_limit;

  assign lvl = q_ff.cfg[BRIGHTNESS_LEVEL_MSB:BRIGHTNESS_LEVEL_LSB];
  assign lvl_ok = (lvl <= LEVEL_LAST);
  assign max_tgt = lvl_ok ? level_max_current : 7'h00;
  assign dim_tgt = lvl_ok ? level_dim_current : 7'h00;
  assign tick_hit = (q_ff.tick == 27'(TICK_CYCLES_P - 1));
  assign dim_limit = (q_ff.dim_timeout_secs != 7'h00) ? q_ff.dim_timeout_secs : q_ff.off_timeout_secs;

  always_comb begin
    fade_tgt = 7'h00;
    if (q_ff.st == ST_FADE_IN) begin
      fade_tgt = max_tgt;
    end else if (q_ff.st == ST_FADE_DIM) begin
      fade_tgt = dim_tgt;
    end
  end

  assign fading = (q_ff.st == ST_FADE_IN || q_ff.st == ST_FADE_DIM || q_ff.st == ST_FADE_OFF)
    && (q_ff.cur != fade_tgt);

  // The override drops the programmed rate and uses the fast 0.1 s ramp.
  always_comb begin
    if (q_ff.cfg[FADE_OVERRIDE_POS]) begin
      rate_code = 4'h0;
    end else if (q_ff.st == ST_FADE_IN) begin
      rate_code = q_ff.rates[FADE_IN_RATE_MSB:FADE_IN_RATE_LSB];
    end else begin
      rate_code = q_ff.rates[FADE_OUT_RATE_MSB:FADE_OUT_RATE_LSB];
    end
  end

  fade_step_timer #(
    .UNIT_CYCLES(FADE_UNIT_CYCLES_P)
  ) u_step (
    .clk(clk),
    .sys_rst(sys_rst),
    .active(fading),
    .rate_code(rate_code),
    .law(q_ff.cfg[TRANSFER_LAW_MSB:TRANSFER_LAW_LSB]),
    .cur_code(q_ff.cur),
    .step(step)
  );

  always_comb begin
    nxt_q = q_ff;
    nxt_q.off_evt = 1'b0;
    nxt_q.tick = tick_hit ? 27'h000_0000 : q_ff.tick + 27'h000_0001;
    if (reg_rd_en) begin
      nxt_q.rdata = 8'h00;
      if (reg_addr == OFS_BACKLIGHT_CONFIG) begin
        nxt_q.rdata = q_ff.cfg;
      end else if (reg_addr == OFS_DIODE_GROUP_SELECT) begin
        nxt_q.rdata = {1'b0, q_ff.grp};
      end else if (reg_addr == OFS_DIODE_PWM_ENABLE) begin
        nxt_q.rdata = {1'b0, q_ff.pwm};
      end else if (reg_addr == OFS_OFF_TIMEOUT) begin
        nxt_q.rdata = {1'b0, q_ff.off_timeout_secs};
      end else if (reg_addr == OFS_DIM_TIMEOUT) begin
        nxt_q.rdata = {1'b0, q_ff.dim_timeout_secs};
      end else if (reg_addr == OFS_FADE_RATES) begin
        nxt_q.rdata = q_ff.rates;
      end
    end
    if (reg_wr_en) begin
      if (reg_addr == OFS_BACKLIGHT_CONFIG) begin
        nxt_q.cfg = reg_wdata;
      end else if (reg_addr == OFS_DIODE_GROUP_SELECT) begin
        nxt_q.grp = reg_wdata[6:0];
      end else if (reg_addr == OFS_DIODE_PWM_ENABLE) begin
        nxt_q.pwm = reg_wdata[6:0];
      end else if (reg_addr == OFS_OFF_TIMEOUT) begin
        nxt_q.off_timeout_secs = reg_wdata[6:0];
      end else if (reg_addr == OFS_DIM_TIMEOUT) begin
        nxt_q.dim_timeout_secs = reg_wdata[6:0];
      end else if (reg_addr == OFS_FADE_RATES) begin
        nxt_q.rates = reg_wdata;
      end
    end
    // Automatic control wins over a software write in the same cycle.
    if (auto_level_enable) begin
      nxt_q.cfg[BRIGHTNESS_LEVEL_MSB:BRIGHTNESS_LEVEL_LSB] =
        q_ff.cfg[SENSOR_SOURCE_SELECT_POS] ? second_light_level : main_light_level;
    end
    if (step) begin
      nxt_q.cur = (q_ff.cur < fade_tgt) ? q_ff.cur + 7'h01 : q_ff.cur - 7'h01;
    end
    if (dim_force && backlight_enable) begin
      nxt_q.dim_mode = 1'b1;
    end
    if (!backlight_enable) begin
      nxt_q.off_latched = 1'b0;
      nxt_q.dim_mode = 1'b0;
      if (q_ff.st != ST_OFF && q_ff.st != ST_FADE_OFF) begin
        nxt_q.st = ST_FADE_OFF;
      end else if (q_ff.st == ST_FADE_OFF && q_ff.cur == 7'h00) begin
        nxt_q.st = ST_OFF;
        nxt_q.off_evt = 1'b1;
      end
    end else begin
      case (q_ff.st)
        ST_OFF: begin
          if (!q_ff.off_latched) begin
            nxt_q.st = ST_FADE_IN;
          end
        end
        ST_FADE_IN: begin
          if (q_ff.cur == max_tgt) begin
            nxt_q.st = ST_AT_MAX;
            nxt_q.tick = 27'h000_0000;
            nxt_q.tcnt = 7'h00;
          end
        end
        ST_AT_MAX: begin
          if (q_ff.dim_mode || dim_force) begin
            nxt_q.st = ST_FADE_DIM;
          end else if (q_ff.cur != max_tgt) begin
            nxt_q.st = ST_FADE_IN;
          end else if (tick_hit && dim_limit != 7'h00) begin
            nxt_q.tcnt = q_ff.tcnt + 7'h01;
            if (q_ff.tcnt + 7'h01 >= dim_limit) begin
              nxt_q.tcnt = 7'h00;
              if (q_ff.dim_timeout_secs != 7'h00) begin
                nxt_q.dim_mode = 1'b1;
                nxt_q.st = ST_FADE_DIM;
              end else begin
                nxt_q.off_latched = 1'b1;
                nxt_q.st = ST_FADE_OFF;
              end
            end
          end
        end
        ST_FADE_DIM: begin
          if (q_ff.cur == dim_tgt) begin
            nxt_q.st = ST_AT_DIM;
            nxt_q.tick = 27'h000_0000;
            nxt_q.tcnt = 7'h00;
          end
        end
        ST_AT_DIM: begin
          if (q_ff.cur != dim_tgt) begin
            nxt_q.st = ST_FADE_DIM;
          end else if (tick_hit && q_ff.off_timeout_secs != 7'h00) begin
            nxt_q.tcnt = q_ff.tcnt + 7'h01;
            if (q_ff.tcnt + 7'h01 >= q_ff.off_timeout_secs) begin
              nxt_q.tcnt = 7'h00;
              nxt_q.off_latched = 1'b1;
              nxt_q.st = ST_FADE_OFF;
            end
          end
        end
        ST_FADE_OFF: begin
          if (q_ff.cur == 7'h00) begin
            nxt_q.st = ST_OFF;
            nxt_q.off_evt = 1'b1;
          end
        end
        default: begin
          nxt_q.st = ST_OFF;
        end
      endcase
    end
    if (nxt_q.st != ST_AT_MAX && nxt_q.st != ST_AT_DIM) begin
      nxt_q.tcnt = 7'h00;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q_ff.cfg <= RST_BACKLIGHT_CONFIG;
      q_ff.grp <= RST_DIODE_GROUP_SELECT;
      q_ff.pwm <= RST_DIODE_PWM_ENABLE;
      q_ff.off_timeout_secs <= RST_OFF_TIMEOUT;
      q_ff.dim_timeout_secs <= RST_DIM_TIMEOUT;
      q_ff.rates <= RST_FADE_RATES;
      q_ff.st <= ST_OFF;
      q_ff.cur <= 7'h00;
      q_ff.tick <= 27'h000_0000;
      q_ff.tcnt <= 7'h00;
      q_ff.dim_mode <= 1'b0;
      q_ff.off_latched <= 1'b0;
      q_ff.off_evt <= 1'b0;
      q_ff.rdata <= 8'h00;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign reg_rdata = q_ff.rdata;
  assign brightness_level = lvl;
  assign transfer_law = q_ff.cfg[TRANSFER_LAW_MSB:TRANSFER_LAW_LSB];
  assign second_sensor_on = q_ff.cfg[SECOND_SENSOR_ENABLE_POS];
  assign backlight_current = q_ff.cur;
  assign dim_mode = q_ff.dim_mode;
  assign backlight_off_event = q_ff.off_evt;

  // Sink six is handed to the second light input, so both its paths close.
  generate
    for (genvar i = 0; i < NUM_DIODES; i++) begin : g_sink
      localparam logic is_six = (i == SINK_SIX_IDX);
      logic blocked;
      assign blocked = is_six && q_ff.cfg[SECOND_SENSOR_ENABLE_POS];
      assign sink_group_on[i] = !q_ff.grp[i] && (q_ff.st != ST_OFF) && !blocked;
      assign sink_independent[i] = q_ff.grp[i] && !blocked;
      assign sink_pwm_gate[i] = q_ff.pwm[i] ? pwm_in : 1'b1;
    end
  endgenerate

  chk_source_second: assert property (@(posedge clk) disable iff (sys_rst)
    auto_level_enable && q_ff.cfg[SENSOR_SOURCE_SELECT_POS]
    |=> brightness_level == $past(second_light_level))
    else $error("level did not follow the second light input");

  chk_sink_six_off: assert property (@(posedge clk) disable iff (sys_rst)
    second_sensor_on |-> !sink_group_on[SINK_SIX_IDX] && !sink_independent[SINK_SIX_IDX])
    else $error("sink six active while second input enabled");

  chk_level_disabled: assert property (@(posedge clk) disable iff (sys_rst)
    (q_ff.st == ST_AT_MAX) && !lvl_ok && $stable(lvl) |-> backlight_current == 7'h00)
    else $error("disabled level left current nonzero");

  chk_manual_write: assert property (@(posedge clk) disable iff (sys_rst)
    reg_wr_en && reg_addr == OFS_BACKLIGHT_CONFIG && !auto_level_enable
    |=> brightness_level == $past(reg_wdata[BRIGHTNESS_LEVEL_MSB:BRIGHTNESS_LEVEL_LSB]))
    else $error("software level write not taken");

  chk_ramp_single: assert property (@(posedge clk) disable iff (sys_rst)
    $changed(backlight_current) |-> $past(step)
    && (backlight_current == $past(q_ff.cur) + 7'h01
    || backlight_current == $past(q_ff.cur) - 7'h01))
    else $error("current jumped instead of ramping");

  chk_off_event: assert property (@(posedge clk) disable iff (sys_rst)
    backlight_off_event |-> $past(q_ff.st) == ST_FADE_OFF && backlight_current == 7'h00
    ##1 !backlight_off_event)
    else $error("off event without a finished fade");

  chk_dim_wait_max: assert property (@(posedge clk) disable iff (sys_rst)
    q_ff.tcnt != 7'h00 |-> q_ff.st == ST_AT_MAX || q_ff.st == ST_AT_DIM)
    else $error("timeout counted before maximum was reached");

  chk_dim_flag: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(dim_mode) |-> $past(backlight_enable))
    else $error("dim mode entered while backlight disabled");

  chk_reserved_zero: assert property (@(posedge clk) disable iff (sys_rst)
    reg_rd_en && reg_addr == OFS_DIODE_GROUP_SELECT |=> reg_rdata[7] == 1'b0)
    else $error("reserved bit read as one");

  chk_pwm_ignore: assert property (@(posedge clk) disable iff (sys_rst)
    !q_ff.pwm[0] |-> sink_pwm_gate[0])
    else $error("sink gated by PWM while scaling disabled");

endmodule
`default_nettype wire

// file: rtl/fade_step_timer.sv
`timescale 1ns/100ps
`default_nettype none
module fade_step_timer #(
  parameter int UNIT_CYCLES = backlight_pkg::FADE_UNIT_CYCLES
) (
  input wire logic clk, // System clock.
  input wire logic sys_rst, // Synchronous reset, active high.
  input wire logic active, // A fade is in progress.
  input wire logic [3:0] rate_code, // Fade rate code in use.
  input wire logic [1:0] law, // Transfer law code.
  input wire logic [6:0] cur_code, // Present current code.
  output logic step // One-cycle pulse: move one current code.
);
  import backlight_pkg::*;

  typedef struct packed {
    logic [31:0] cnt;
  } step_st_t;

  step_st_t q_ff;
  step_st_t nxt_q;
  logic [31:0] base;
  logic [31:0] period;

  function automatic int fade_tenths(input logic [3:0] code);
    if (code == 4'h0) begin
      return FADE_TENTHS_FAST;
    end else if (int'(code) <= FADE_CODE_FINE_LAST) begin
      return FADE_TENTHS_FINE_STEP * int'(code);
    end else begin
      return FADE_TENTHS_FINE_STEP * FADE_CODE_FINE_LAST
        + FADE_TENTHS_COARSE_STEP * (int'(code) - FADE_CODE_FINE_LAST);
    end
  endfunction

  // The step period per code is fixed by the rate, so a short swing ends early.
  always_comb begin
    base = 32'(fade_tenths(rate_code) * UNIT_CYCLES);
    period = base;
    // The cubic laws bend the time per code but keep the full-scale total.
    if (law == LAW_CUBIC_10) begin
      period = (cur_code < CODE_MID_SCALE) ? base + (base >> 1) : (base >> 1);
    end else if (law == LAW_CUBIC_11) begin
      period = (cur_code < CODE_MID_SCALE) ? (base >> 1) : base + (base >> 1);
    end
    if (period == 32'h0000_0000) begin
      period = 32'h0000_0001;
    end
  end

  always_comb begin
    nxt_q = q_ff;
    if (!active || step) begin
      nxt_q.cnt = 32'h0000_0000;
    end else begin
      nxt_q.cnt = q_ff.cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign step = active && (q_ff.cnt >= period - 32'h0000_0001);

  chk_step_spacing: assert property (@(posedge clk) disable iff (sys_rst)
    step && active |=> !step)
    else $error("fade steps came back to back");

endmodule
`default_nettype wire

// file: shared/backlight_pkg.sv
package backlight_pkg;

  // Register offsets of the backlight configuration bank.
  localparam logic [7:0] OFS_BACKLIGHT_CONFIG = 8'h04;
  localparam logic [7:0] OFS_DIODE_GROUP_SELECT = 8'h05;
  localparam logic [7:0] OFS_DIODE_PWM_ENABLE = 8'h06;
  localparam logic [7:0] OFS_OFF_TIMEOUT = 8'h07;
  localparam logic [7:0] OFS_DIM_TIMEOUT = 8'h08;
  localparam logic [7:0] OFS_FADE_RATES = 8'h09;

  // Field positions inside backlight_config.
  localparam int SENSOR_SOURCE_SELECT_POS = 7;
  localparam int SECOND_SENSOR_ENABLE_POS = 6;
  localparam int BRIGHTNESS_LEVEL_MSB = 5;
  localparam int BRIGHTNESS_LEVEL_LSB = 3;
  localparam int TRANSFER_LAW_MSB = 2;
  localparam int TRANSFER_LAW_LSB = 1;
  localparam int FADE_OVERRIDE_POS = 0;

  // Field positions inside fade_rates.
  localparam int FADE_OUT_RATE_MSB = 7;
  localparam int FADE_OUT_RATE_LSB = 4;
  localparam int FADE_IN_RATE_MSB = 3;
  localparam int FADE_IN_RATE_LSB = 0;

  // Diode whose sink gives way to the second light input.
  localparam int SINK_SIX_IDX = 5;
  localparam int NUM_DIODES = 7;

  // Reset values.
  localparam logic [7:0] RST_BACKLIGHT_CONFIG = 8'h00;
  localparam logic [6:0] RST_DIODE_GROUP_SELECT = 7'h00;
  localparam logic [6:0] RST_DIODE_PWM_ENABLE = 7'h00;
  localparam logic [6:0] RST_OFF_TIMEOUT = 7'h00;
  localparam logic [6:0] RST_DIM_TIMEOUT = 7'h00;
  localparam logic [7:0] RST_FADE_RATES = 8'h00;

  // Highest level code that selects a real level.
  localparam logic [2:0] LEVEL_LAST = 3'h4;

  // Transfer law codes.
  localparam logic [1:0] LAW_CUBIC_10 = 2'h2;
  localparam logic [1:0] LAW_CUBIC_11 = 2'h3;

  // Current codes: full scale is 30 mA.
  localparam logic [6:0] CODE_FULL_SCALE = 7'h7f;
  localparam logic [6:0] CODE_MID_SCALE = 7'h40;
  localparam int FULL_SCALE_CODES = 127;

  // Timing.
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_TIME_MS = 1000;
  localparam int TICK_CYCLES = TICK_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int FADE_UNIT_MS = 100;
  localparam int FADE_UNIT_CYCLES = FADE_UNIT_MS * 1000000 / CLK_PERIOD_NS / FULL_SCALE_CODES;

  // Fade time encoding, counted in tenths of a second.
  localparam int FADE_TENTHS_FAST = 1;
  localparam int FADE_TENTHS_FINE_STEP = 3;
  localparam int FADE_TENTHS_COARSE_STEP = 5;
  localparam int FADE_CODE_FINE_LAST = 10;

  typedef enum logic [5:0] {
    ST_OFF = 6'h01,
    ST_FADE_IN = 6'h02,
    ST_AT_MAX = 6'h04,
    ST_FADE_DIM = 6'h08,
    ST_AT_DIM = 6'h10,
    ST_FADE_OFF = 6'h20
  } seq_state_t;

endpackage

// file: testbench/backlight_level_fade_control_bench.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin fail_count++; $display("[ERR] %s expected %0h seen %0h", nm, e, g); end end
module backlight_level_fade_control_bench;
  import backlight_pkg::*;
  localparam int TK = 20;
  localparam int FU = 2;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic wr = 1'b0, rd = 1'b0, en = 1'b0, auto_en = 1'b0, dimf = 1'b0, pwm = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00;
  logic [2:0] ml = 3'h0, sl = 3'h0;
  logic [6:0] mx = 7'h00, dm = 7'h00;
  logic [7:0] rdata;
  logic [2:0] lvl;
  logic [1:0] law;
  logic s2_on, dim_mode, off_evt;
  logic [6:0] cur, grp_on, indep, gate;
  int fail_count = 0;
  int tests_run = 0;
  int n;
  logic [7:0] a, d;
  logic [6:0] sel;
  logic b6;
  int fi_t[8] = '{0, 1, 10, 15, 1, 1, 1, 15};
  int law_t[8] = '{0, 0, 0, 0, 1, 2, 3, 0};
  int ov_t[8] = '{0, 0, 0, 0, 0, 0, 0, 1};
  // Step periods with FU cycles per tenth; cubic laws bend the period below code 64.
  int per_t[8] = '{2, 6, 60, 110, 6, 9, 3, 2};

  always #5 clk = ~clk;

  backlight_level_fade_control #(.TICK_CYCLES_P(TK), .FADE_UNIT_CYCLES_P(FU)) DUT (
    .clk(clk), .sys_rst(sys_rst), .reg_wr_en(wr), .reg_rd_en(rd), .reg_addr(addr),
    .reg_wdata(wdata), .reg_rdata(rdata), .backlight_enable(en), .auto_level_enable(auto_en),
    .dim_force(dimf), .main_light_level(ml), .second_light_level(sl),
    .level_max_current(mx), .level_dim_current(dm), .pwm_in(pwm),
    .brightness_level(lvl), .transfer_law(law), .second_sensor_on(s2_on),
    .backlight_current(cur), .sink_group_on(grp_on), .sink_independent(indep),
    .sink_pwm_gate(gate), .dim_mode(dim_mode), .backlight_off_event(off_evt));

  task give_verdict();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task tick(input int c);
    repeat (c) @(negedge clk);
  endtask

  task do_reset();
    en = 1'b0;
    auto_en = 1'b0;
    sys_rst = 1'b1;
    tick(2);
    sys_rst = 1'b0;
  endtask

  task wr_reg(input logic [7:0] ad, input logic [7:0] dt);
    wr = 1'b1;
    addr = ad;
    wdata = dt;
    tick(1);
    wr = 1'b0;
    tick(1);
  endtask

  task rd_chk(input logic [7:0] ad, input logic [7:0] e, input string nm);
    rd = 1'b1;
    addr = ad;
    tick(1);
    rd = 1'b0;
    `CHK(nm, e, rdata)
    tick(1);
  endtask

  function automatic bit hit(input int k, input logic [6:0] t);
    if (k == 0) return cur === t;
    if (k == 1) return dim_mode === 1'b1;
    return off_evt === 1'b1;
  endfunction

  // Kind 0 waits for a current code, 1 for the dim flag, 2 for the off pulse.
  task wait_on(input int k, input logic [6:0] t, input int lim, output int c);
    c = 0;
    while (!hit(k, t) && c < lim) begin
      tick(1);
      c++;
    end
    if (!hit(k, t)) begin
      fail_count++;
      $display("[ERR] wait kind %0d expected hit seen timeout", k);
      give_verdict();
    end
  endtask

  function automatic logic [6:0] blk(input logic s6);
    return {1'b0, s6, 5'h00};
  endfunction

  initial begin
    void'($urandom(43));
    do_reset();
    for (int i = 4; i <= 9; i++) rd_chk(i[7:0], 8'h00, "reset value");
    rd_chk(8'h0a, 8'h00, "unmapped read");
    $display("test reset_values done");
    for (int i = 0; i < 24; i++) begin
      a = 8'h04 + 8'($urandom % 6);
      d = 8'($urandom);
      wr_reg(a, d);
      rd_chk(a, (a inside {[8'h05:8'h08]}) ? (d & 8'h7f) : d, "readback");
      if (a == 8'h04) begin
        `CHK("law", d[2:1], law)
        `CHK("sensor two", d[6], s2_on)
        `CHK("level", d[5:3], lvl)
      end
      if (a == 8'h06) for (int p = 0; p < 2; p++) begin
        pwm = p[0];
        tick(1);
        `CHK("pwm gate", (d[6:0] & {7{p[0]}}) | ~d[6:0], gate)
      end
      `CHK("group off", 7'h00, grp_on)
    end
    $display("test register_traffic done");
    for (int lv = 0; lv < 8; lv++) begin
      do_reset();
      sel = 7'($urandom);
      b6 = 1'($urandom);
      wr_reg(8'h05, {1'b0, sel});
      wr_reg(8'h04, {1'b0, b6, lv[2:0], 3'h1});
      mx = 7'h04;
      en = 1'b1;
      tick(30);
      `CHK("level current", (lv > 4) ? 7'h00 : 7'h04, cur)
      `CHK("level field", lv[2:0], lvl)
      `CHK("independent", sel & ~blk(b6), indep)
      `CHK("group on", ~sel & ~blk(b6), grp_on)
    end
    ml = 3'h2;
    sl = 3'h3;
    auto_en = 1'b1;
    tick(3);
    `CHK("auto main", 3'h2, lvl)
    wr_reg(8'h04, 8'h81);
    tick(2);
    `CHK("auto second", 3'h3, lvl)
    rd_chk(8'h04, 8'h99, "auto readback");
    $display("test levels_and_sinks done");
    for (int i = 0; i < 8; i++) begin
      do_reset();
      wr_reg(8'h04, {5'h00, law_t[i][1:0], ov_t[i][0]});
      wr_reg(8'h09, {fi_t[i][3:0], fi_t[i][3:0]});
      mx = 7'h03;
      en = 1'b1;
      wait_on(0, 7'h03, 600, n);
      `CHK("fade in time", 1'b1, n >= 3 * per_t[i] - 1 && n <= 3 * per_t[i] + 4)
      tick(3);
      en = 1'b0;
      wait_on(2, 7'h00, 600, n);
      `CHK("fade out time", 1'b1, n >= 3 * per_t[i] - 1 && n <= 3 * per_t[i] + 4)
      tick(1);
      `CHK("off pulse width", 1'b0, off_evt)
    end
    $display("test fade_rates done");
    do_reset();
    wr_reg(8'h04, 8'h01);
    wr_reg(8'h08, 8'h02);
    wr_reg(8'h07, 8'h03);
    mx = 7'h04;
    dm = 7'h02;
    en = 1'b1;
    wait_on(0, 7'h04, 100, n);
    wait_on(1, 7'h00, 200, n);
    `CHK("dim delay", 1'b1, n >= 2 * TK - 1 && n <= 2 * TK + 3)
    wait_on(0, 7'h02, 50, n);
    wait_on(2, 7'h00, 300, n);
    `CHK("off delay", 1'b1, n >= 3 * TK && n <= 3 * TK + 8)
    tick(50);
    `CHK("stays off", 7'h00, cur)
    en = 1'b0;
    tick(3);
    dimf = 1'b1;
    tick(2);
    dimf = 1'b0;
    `CHK("dim refused", 1'b0, dim_mode)
    wr_reg(8'h08, 8'h00);
    wr_reg(8'h07, 8'h00);
    en = 1'b1;
    wait_on(0, 7'h04, 100, n);
    dimf = 1'b1;
    tick(1);
    dimf = 1'b0;
    wait_on(1, 7'h00, 5, n);
    wait_on(0, 7'h02, 50, n);
    tick(100);
    `CHK("no off timeout", 7'h02, cur)
    $display("test timeouts done");
    give_verdict();
  end
endmodule
`default_nettype wire
